//--- design/fwp_flash_dev.sv
// Flash device end: frame capture on the link clock, protection and op timing
`timescale 1ns/1ps
module fwp_flash_dev
	import fwp_pkg::*;
#(
	parameter int unsigned PROG_CYC = PROG_TYP_CYC,
	parameter int unsigned ERASE_CYC = ERASE_TYP_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	fwp_if.device link,
	output logic [10:0] status_out,
	output logic op_done,
	output logic cmd_rejected
);

	// ------------------------------------------------------------
	// Link clock domain: bit counter and captured frame bytes
	// ------------------------------------------------------------
	typedef struct packed {
		logic [LEN_W-1:0] cnt;
		logic [7:0] sh;
		logic [7:0] op;
		logic [23:0] adr;
		logic [7:0] st_s1;
		logic [7:0] st_s2;
	} fwp_lnk_t;

	typedef struct packed {
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic wp_s1;
		logic wp_s2;
		fwp_dev_st_t st;
		logic write_enable_latch;
		logic [4:0] bp;
		logic status_lock_bit0;
		logic status_lock_bit1;
		logic [TMR_W-1:0] tmr;
		logic done;
		logic rej;
	} fwp_core_t;

	fwp_lnk_t l_r;
	fwp_lnk_t l_nxt;
	fwp_core_t c_r;
	fwp_core_t c_nxt;
	logic armed_r;
	logic miso_r;
	logic [7:0] nbyte;
	logic [7:0] stat_byte;
	logic frame_end;
	logic aligned;
	logic is_write;
	logic len_ok;
	logic [TMR_W-1:0] busy_cyc;
	logic [ADR_W-1:0] t_mask;
	logic [ADR_W-1:0] t_lo;
	logic [ADR_W-1:0] t_hi;
	logic prot_hit;
	logic [7:0] sr1_byte;

	// Armed while select is high; the first edge of a frame restarts the count.
	// The frame registers are left intact after select rises so the core can read them.
	always_ff @(posedge link.sclk or posedge link.cs_n) begin
		if (link.cs_n) begin
			armed_r <= 1'b1;
		end else begin
			armed_r <= 1'b0;
		end
	end

	// Shift in on rising edges, keep opcode and up to three following bytes
	always_comb begin
		l_nxt = l_r;
		nbyte = {l_r.sh[6:0], link.mosi};
		l_nxt.sh = nbyte;
		l_nxt.st_s1 = stat_byte;
		l_nxt.st_s2 = l_r.st_s1;
		if (armed_r) begin
			l_nxt.cnt = 12'h001;
		end else if (l_r.cnt != 12'hfff) begin
			l_nxt.cnt = l_r.cnt + 12'h001; // Saturates, never wraps to a valid length
		end
		if (l_nxt.cnt == LEN_OP) begin
			l_nxt.op = nbyte;
		end else if (l_nxt.cnt[2:0] == 3'h0 && l_nxt.cnt <= LEN_ADR) begin
			l_nxt.adr = {l_r.adr[15:0], nbyte};
		end
	end

	always_ff @(posedge link.sclk or negedge rstn) begin
		if (!rstn) begin
			l_r <= '0;
		end else begin
			l_r <= l_nxt;
		end
	end

	// Read data leaves on falling edges; status is quasi-static during a frame
	always_ff @(negedge link.sclk or negedge rstn) begin
		if (!rstn) begin
			miso_r <= 1'b0;
		end else if (l_r.op == OP_RD_STAT && l_r.cnt >= LEN_OP) begin
			miso_r <= l_r.st_s2[3'h7 - l_r.cnt[2:0]];
		end else begin
			miso_r <= (l_r.op == OP_READ && l_r.cnt >= LEN_ADR);
		end
	end

	assign link.miso = miso_r;
	assign link.miso_oe = !link.cs_n;

	// ------------------------------------------------------------
	// Core clock domain: decode at select release
	// ------------------------------------------------------------
	assign stat_byte = {c_r.status_lock_bit0, c_r.bp, c_r.write_enable_latch, c_r.st == DS_BUSY};
	assign frame_end = c_r.cs_s2 && !c_r.cs_s3;
	assign aligned = (l_r.cnt[2:0] == 3'h0) && (l_r.cnt != '0);
	assign t_lo = l_r.adr[ADR_W-1:0] & ~t_mask;
	assign t_hi = l_r.adr[ADR_W-1:0] | t_mask;
	assign sr1_byte = (l_r.cnt == LEN_SR1) ? l_r.adr[7:0] : l_r.adr[15:8];

	// Target extent, exact length (minimum length for program) and duration of each data-changing command
	always_comb begin
		is_write = 1'b1;
		len_ok = (l_r.cnt == LEN_ADR);
		busy_cyc = TMR_W'(ERASE_CYC);
		t_mask = MASK_PAGE;
		case (l_r.op)
			OP_PROG: begin
				len_ok = (l_r.cnt >= LEN_PROG_MIN);
				busy_cyc = TMR_W'(PROG_CYC);
			end
			OP_ERS_PAGE: t_mask = MASK_PAGE;
			OP_ERS_SECT: t_mask = MASK_SECT;
			OP_ERS_32K: t_mask = MASK_32K;
			OP_ERS_64K: t_mask = MASK_64K;
			OP_ERS_CHIP, OP_ERS_CHIP2: begin
				t_mask = MASK_CHIP;
				len_ok = (l_r.cnt == LEN_OP);
			end
			default: is_write = 1'b0;
		endcase
	end

	fwp_prot_check u_prot (
		.bp(c_r.bp),
		.t_lo(t_lo),
		.t_hi(t_hi),
		.hit(prot_hit)
	);

	// Busy countdown, then command decode; guards look at the post-countdown state
	always_comb begin
		c_nxt = c_r;
		c_nxt.cs_s1 = link.cs_n;
		c_nxt.cs_s2 = c_r.cs_s1;
		c_nxt.cs_s3 = c_r.cs_s2;
		c_nxt.wp_s1 = link.wp_n;
		c_nxt.wp_s2 = c_r.wp_s1;
		c_nxt.done = 1'b0;
		c_nxt.rej = 1'b0;
		if (c_r.st == DS_BUSY) begin
			c_nxt.tmr = c_r.tmr - 1'b1;
			if (c_r.tmr <= 1) begin
				c_nxt.st = DS_STANDBY;
				c_nxt.done = 1'b1;
			end
		end
		if (frame_end) begin
			c_nxt.rej = 1'b1;
			if (!aligned) begin
				c_nxt.rej = 1'b1;
			end else if (c_nxt.st == DS_DEEP_PD) begin
				if (l_r.op == OP_RELEASE_PD) begin
					c_nxt.st = DS_STANDBY;
					c_nxt.rej = 1'b0;
				end
			end else if (is_write) begin
				// Protected targets are dropped whole, latch untouched
				if (len_ok && c_r.write_enable_latch && c_nxt.st == DS_STANDBY && !prot_hit) begin
					c_nxt.st = DS_BUSY;
					c_nxt.tmr = busy_cyc;
					c_nxt.write_enable_latch = 1'b0;
					c_nxt.rej = 1'b0;
				end
			end else begin
				case (l_r.op)
					OP_SET_WL, OP_CLR_WL: begin
						if (l_r.cnt == LEN_OP) begin
							c_nxt.write_enable_latch = (l_r.op == OP_SET_WL);
							c_nxt.rej = 1'b0;
						end
					end
					OP_WR_STAT: begin
						if ((l_r.cnt == LEN_SR1 || l_r.cnt == LEN_SR2) && c_r.write_enable_latch && c_nxt.st == DS_STANDBY) begin
							c_nxt.write_enable_latch = 1'b0;
							c_nxt.rej = 1'b0;
							if (c_r.wp_s2) begin
								c_nxt.bp = sr1_byte[6:2];
								c_nxt.status_lock_bit0 = sr1_byte[7];
								if (l_r.cnt == LEN_SR2) begin
									c_nxt.status_lock_bit1 = l_r.adr[0];
								end
							end
						end
					end
					OP_SUSPEND: begin
						if (l_r.cnt == LEN_OP && c_nxt.st == DS_BUSY) begin
							c_nxt.st = DS_SUSPENDED;
							c_nxt.rej = 1'b0;
						end
					end
					OP_RESUME: begin
						if (l_r.cnt == LEN_OP && c_nxt.st == DS_SUSPENDED) begin
							c_nxt.st = DS_BUSY;
							c_nxt.rej = 1'b0;
						end
					end
					OP_DEEP_PD: begin
						if (l_r.cnt == LEN_OP && c_nxt.st == DS_STANDBY) begin
							c_nxt.st = DS_DEEP_PD;
							c_nxt.rej = 1'b0;
						end
					end
					OP_RD_STAT, OP_READ, OP_RELEASE_PD: c_nxt.rej = 1'b0;
					default: c_nxt.rej = 1'b1;
				endcase
			end
		end
	end

	// Power-on reset: standby, latch clear, status all zero
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			c_r <= '0;
			c_r.cs_s1 <= 1'b1;
			c_r.cs_s2 <= 1'b1;
			c_r.cs_s3 <= 1'b1;
			c_r.wp_s1 <= 1'b1;
			c_r.wp_s2 <= 1'b1;
			{c_r.status_lock_bit0, c_r.bp, c_r.write_enable_latch} <= STATUS_RESET[7:1];
		end else begin
			c_r <= c_nxt;
		end
	end

	assign status_out = {c_r.st == DS_DEEP_PD, c_r.st == DS_SUSPENDED, c_r.status_lock_bit1, stat_byte};
	assign op_done = c_r.done;
	assign cmd_rejected = c_r.rej;

endmodule : fwp_flash_dev

//--- design/fwp_if.sv
// Serial flash link between host controller and flash device
`timescale 1ns/1ps
interface fwp_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic wp_n;
	logic miso;
	logic miso_oe;
	logic miso_line;

	// Pulled high when the device leaves the data line undriven
	assign miso_line = miso_oe ? miso : 1'b1;

	modport host (output cs_n, output sclk, output mosi, output wp_n, input miso_line);
	modport device (input cs_n, input sclk, input mosi, input wp_n, output miso, output miso_oe);
endinterface : fwp_if

//--- design/fwp_pkg.sv
// Shared constants and types for the flash write-protect link
package fwp_pkg;

	// ------------------------------------------------------------
	// Command opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_SET_WL = 8'h06;
	localparam logic [7:0] OP_CLR_WL = 8'h04;
	localparam logic [7:0] OP_RD_STAT = 8'h05;
	localparam logic [7:0] OP_WR_STAT = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_ERS_PAGE = 8'h81;
	localparam logic [7:0] OP_ERS_SECT = 8'h20;
	localparam logic [7:0] OP_ERS_32K = 8'h52;
	localparam logic [7:0] OP_ERS_64K = 8'hd8;
	localparam logic [7:0] OP_ERS_CHIP = 8'hc7;
	localparam logic [7:0] OP_ERS_CHIP2 = 8'h60;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	localparam logic [7:0] OP_DEEP_PD = 8'hb9;
	localparam logic [7:0] OP_RELEASE_PD = 8'hab;

	// ------------------------------------------------------------
	// Array geometry, frame lengths, status reset
	// ------------------------------------------------------------
	localparam int ADR_W = 22;
	localparam int LEN_W = 12;
	localparam logic [ADR_W-1:0] MASK_PAGE = 22'h0000ff;
	localparam logic [ADR_W-1:0] MASK_SECT = 22'h000fff;
	localparam logic [ADR_W-1:0] MASK_32K = 22'h007fff;
	localparam logic [ADR_W-1:0] MASK_64K = 22'h00ffff;
	localparam logic [ADR_W-1:0] MASK_CHIP = 22'h3fffff;
	localparam logic [ADR_W:0] ARRAY_SIZE = 23'h400000;
	localparam logic [ADR_W:0] PROT_BIG_UNIT = 23'h010000;
	localparam logic [ADR_W:0] PROT_SMALL_UNIT = 23'h001000;
	localparam logic [LEN_W-1:0] LEN_OP = 12'h008;
	localparam logic [LEN_W-1:0] LEN_SR1 = 12'h010;
	localparam logic [LEN_W-1:0] LEN_SR2 = 12'h018;
	localparam logic [LEN_W-1:0] LEN_ADR = 12'h020;
	localparam logic [LEN_W-1:0] LEN_PROG_MIN = 12'h028;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 40;
	localparam int PROG_TYP_US = 2000;
	localparam int PROG_MAX_US = 3000;
	localparam int ERASE_TYP_US = 10000;
	localparam int ERASE_MAX_US = 20000;
	localparam int PROG_TYP_CYC = PROG_TYP_US * 1000 / CLK_NS;
	localparam int ERASE_TYP_CYC = ERASE_TYP_US * 1000 / CLK_NS;
	localparam int TMR_W = 18;
	localparam int PWRUP_NS = 70000;
	localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PWR_W = 11;
	localparam int RESUME_GAP_NS = 300;
	localparam int RESUME_GAP_CYC = (RESUME_GAP_NS + CLK_NS - 1) / CLK_NS;
	localparam int RESUME_RUN_US = 350;
	localparam int RESUME_RUN_CYC = (RESUME_RUN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int RUN_W = 14;
	localparam logic [2:0] GAP_LAST = 3'h7;

	// ------------------------------------------------------------
	// Host register map (APB byte addresses) and command fields
	// ------------------------------------------------------------
	localparam logic [11:0] REG_CMD = 12'h000;
	localparam logic [11:0] REG_ARG = 12'h004;
	localparam logic [11:0] REG_STAT = 12'h008;
	localparam logic [11:0] REG_CTRL = 12'h00c;
	localparam int CMD_NB_LSB = 8;
	localparam int CMD_AUTO_WL = 11;
	localparam int CMD_DROP_BIT = 12;

	// ------------------------------------------------------------
	// State types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DS_STANDBY = 2'b00,
		DS_BUSY = 2'b01,
		DS_SUSPENDED = 2'b10,
		DS_DEEP_PD = 2'b11
	} fwp_dev_st_t;

	typedef enum logic [1:0] {
		HS_PWRUP = 2'b00,
		HS_IDLE = 2'b01,
		HS_FRAME = 2'b10,
		HS_GAP = 2'b11
	} fwp_host_st_t;

endpackage : fwp_pkg

//--- design/fwp_prot_check.sv
// Block-protect decoder: flags a target range touching the protected area
`timescale 1ns/1ps
module fwp_prot_check
	import fwp_pkg::*;
(
	input wire logic [4:0] bp,
	input wire logic [ADR_W-1:0] t_lo,
	input wire logic [ADR_W-1:0] t_hi,
	output logic hit
);
	logic [2:0] code;
	logic [2:0] shift;
	logic [ADR_W:0] size;
	logic [ADR_W:0] p_lo;
	logic [ADR_W:0] p_hi;

	// Size from the low code and the unit bit, end of array from the direction bit
	always_comb begin
		code = bp[2:0];
		shift = code - 3'h1;
		if (bp[4]) begin
			size = PROT_SMALL_UNIT << ((code >= 3'h4) ? 3'h3 : shift);
		end else begin
			size = PROT_BIG_UNIT << shift;
		end
		p_lo = bp[3] ? '0 : ARRAY_SIZE - size;
		p_hi = bp[3] ? size - 23'h000001 : ARRAY_SIZE - 23'h000001;
		if (code == 3'h0) begin
			hit = 1'b0;
		end else if (code == 3'h7) begin
			hit = 1'b1;
		end else begin
			hit = ({1'b0, t_lo} <= p_hi) && ({1'b0, t_hi} >= p_lo);
		end
	end
endmodule : fwp_prot_check

//--- design/fwp_spi_host.sv
// Host end: APB command registers driving serial flash frames
`timescale 1ns/1ps
module fwp_spi_host
	import fwp_pkg::*;
#(
	parameter int unsigned RUN_CYC = RESUME_RUN_CYC
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	fwp_if.host link
);

	typedef struct packed {
		fwp_host_st_t st;
		logic [PWR_W-1:0] pwr;
		logic [12:0] cmd;
		logic [31:0] arg;
		logic wp;
		logic go;
		logic wl_sent;
		logic main;
		logic [47:0] tx;
		logic [6:0] bits;
		logic [2:0] ph;
		logic [2:0] gap;
		logic [7:0] rx;
		logic [RUN_W-1:0] run;
		logic miso_s1;
		logic miso_s2;
		logic cs_n;
		logic sclk;
		logic mosi;
		logic [31:0] rdata;
	} fwp_host_core_t;

	fwp_host_core_t h_r;
	fwp_host_core_t h_nxt;
	logic mapped;
	logic apb_wr;
	logic [RUN_W-1:0] run_load;

	assign mapped = (paddr == REG_CMD) || (paddr == REG_ARG) || (paddr == REG_STAT) || (paddr == REG_CTRL);
	assign apb_wr = psel && penable && pwrite;
	// The suspend hold covers both the short gap and the progress window
	assign run_load = (RUN_CYC > RESUME_GAP_CYC) ? RUN_W'(RUN_CYC) : RUN_W'(RESUME_GAP_CYC);

	// ------------------------------------------------------------
	// Register access and frame sequencer
	// ------------------------------------------------------------
	always_comb begin
		h_nxt = h_r;
		h_nxt.miso_s1 = link.miso_line;
		h_nxt.miso_s2 = h_r.miso_s1;
		if (h_r.run != '0) begin
			h_nxt.run = h_r.run - 1'b1;
		end
		// Read data is captured in the setup cycle so it comes from a flop
		if (psel && !penable) begin
			case (paddr)
				REG_CMD: h_nxt.rdata = {19'h0, h_r.cmd};
				REG_ARG: h_nxt.rdata = h_r.arg;
				REG_STAT: h_nxt.rdata = {16'h0, h_r.rx, 5'h0, h_r.st != HS_PWRUP, h_r.run != '0, h_r.go};
				REG_CTRL: h_nxt.rdata = {31'h0, h_r.wp};
				default: h_nxt.rdata = 32'h0;
			endcase
		end
		if (apb_wr) begin
			case (paddr)
				REG_CMD: begin
					if (!h_r.go) begin // A new command while one is pending is dropped
						h_nxt.cmd = pwdata[12:0];
						h_nxt.go = 1'b1;
					end
				end
				REG_ARG: h_nxt.arg = pwdata;
				REG_CTRL: h_nxt.wp = pwdata[0];
				default: h_nxt.rdata = h_nxt.rdata;
			endcase
		end
		case (h_r.st)
			HS_PWRUP: begin
				if (h_r.pwr == PWR_W'(PWRUP_CYC - 1)) begin
					h_nxt.st = HS_IDLE;
				end else begin
					h_nxt.pwr = h_r.pwr + 1'b1;
				end
			end
			HS_IDLE: begin
				h_nxt.ph = 3'h0;
				if (h_r.go && h_r.cmd[CMD_AUTO_WL] && !h_r.wl_sent) begin
					h_nxt.tx = {OP_SET_WL, 40'h0};
					h_nxt.bits = 7'h08;
					h_nxt.wl_sent = 1'b1;
					h_nxt.main = 1'b0;
					h_nxt.st = HS_FRAME;
					h_nxt.cs_n = 1'b0;
					h_nxt.mosi = OP_SET_WL[7];
				end else if (h_r.go && !(h_r.cmd[7:0] == OP_SUSPEND && h_r.run != '0)) begin
					h_nxt.tx = {h_r.cmd[7:0], h_r.arg, 8'h0};
					h_nxt.bits = {1'b0, h_r.cmd[CMD_NB_LSB+:3], 3'h0} + 7'h08 - {6'h0, h_r.cmd[CMD_DROP_BIT]};
					h_nxt.main = 1'b1;
					h_nxt.st = HS_FRAME;
					h_nxt.cs_n = 1'b0;
					h_nxt.mosi = h_r.cmd[7];
				end
			end
			HS_FRAME: begin
				h_nxt.ph = h_r.ph + 3'h1;
				// Last phase of a bit: sample, shift, move on
				if (h_r.ph == 3'h7) begin
					h_nxt.rx = {h_r.rx[6:0], h_r.miso_s2};
					h_nxt.tx = {h_r.tx[46:0], 1'b0};
					h_nxt.mosi = h_r.tx[46];
					h_nxt.bits = h_r.bits - 7'h01;
					if (h_r.bits == 7'h01) begin
						h_nxt.st = HS_GAP;
						h_nxt.cs_n = 1'b1;
						h_nxt.gap = 3'h0;
						if (h_r.main) begin
							h_nxt.go = 1'b0;
							h_nxt.wl_sent = 1'b0;
							h_nxt.main = 1'b0;
							// The shift register no longer holds the opcode here, so decode the command word
							if (h_r.cmd[7:0] == OP_RESUME) begin
								h_nxt.run = run_load;
							end
						end
					end
				end
			end
			HS_GAP: begin
				// Select stays high long enough for the device to decode the frame
				h_nxt.gap = h_r.gap + 3'h1;
				if (h_r.gap == GAP_LAST) begin
					h_nxt.st = HS_IDLE;
				end
			end
			default: h_nxt.st = HS_IDLE;
		endcase
		h_nxt.sclk = (h_nxt.st == HS_FRAME) && h_nxt.ph[2];
	end

	// Select high from reset through the power-up wait
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			h_r <= '0;
			h_r.cs_n <= 1'b1;
			h_r.wp <= 1'b1;
		end else begin
			h_r <= h_nxt;
		end
	end

	assign prdata = h_r.rdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign link.cs_n = h_r.cs_n;
	assign link.sclk = h_r.sclk;
	assign link.mosi = h_r.mosi;
	assign link.wp_n = h_r.wp;

endmodule : fwp_spi_host

//--- verification/fwp_checker.sv
// Assertion checker for the flash link and the device status outputs
`timescale 1ns/1ps
module fwp_checker
	import fwp_pkg::*;
#(
	parameter int unsigned ERASE_CYC = 400
) (
	input wire logic clk_sys,
	input wire logic clk_dev,
	input wire logic rstn,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic wp_n,
	input wire logic miso_line,
	input wire logic [10:0] status_out,
	input wire logic op_done,
	input wire logic cmd_rejected
);
	// ------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------
	logic [11:0] age_r;
	logic [11:0] age_nxt;
	logic [19:0] run_r;
	logic [19:0] run_nxt;

	// Age saturates so a long run never wraps back into the power-up window
	assign age_nxt = (age_r == 12'hfff) ? age_r : age_r + 12'h001;
	// Busy time is frozen while suspended and cleared once idle
	assign run_nxt = status_out[0] ? run_r + 20'h00001 : (status_out[9] ? run_r : 20'h00000);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			age_r <= 12'h000;
		end else begin
			age_r <= age_nxt;
		end
	end

	always_ff @(posedge clk_dev or negedge rstn) begin
		if (!rstn) begin
			run_r <= 20'h00000;
		end else begin
			run_r <= run_nxt;
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	sequence s_sclk_high;
		sclk [*4] ##1 !sclk;
	endsequence

	a_pwrup_select_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
		(age_r < PWRUP_CYC) |-> cs_n) else $error("select driven low during power-up wait");
	a_sclk_idle_low: assert property (@(posedge clk_sys) disable iff (!rstn)
		cs_n |-> !sclk) else $error("link clock not low between frames");
	a_sclk_divide: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(sclk) |-> s_sclk_high) else $error("link clock high phase not four cycles");
	a_idle_pull_up: assert property (@(posedge clk_sys) disable iff (!rstn)
		cs_n |-> miso_line) else $error("data line not released between frames");
	a_done_on_fall: assert property (@(posedge clk_dev) disable iff (!rstn)
		op_done |-> $fell(status_out[0]) && !status_out[9]) else $error("done pulse without busy end");
	a_busy_bounded: assert property (@(posedge clk_dev) disable iff (!rstn)
		run_r <= ERASE_CYC + 2) else $error("operation busy too long");
	a_suspend_from_busy: assert property (@(posedge clk_dev) disable iff (!rstn)
		$rose(status_out[9]) |-> $past(status_out[0])) else $error("suspend entered while not busy");
	a_latch_before_busy: assert property (@(posedge clk_dev) disable iff (!rstn)
		$rose(status_out[0]) && !$past(status_out[9]) |-> $past(status_out[1]) && !status_out[1])
		else $error("operation started without write latch");
	a_pd_frozen: assert property (@(posedge clk_dev) disable iff (!rstn)
		status_out[10] |=> $stable(status_out[9:0])) else $error("status changed in deep power-down");
	a_wp_freeze: assert property (@(posedge clk_dev) disable iff (!rstn)
		(!wp_n) [*4] |=> $stable(status_out[8:2])) else $error("protect bits changed with pin low");
	a_reject_pulse: assert property (@(posedge clk_dev) disable iff (!rstn)
		cmd_rejected |=> !cmd_rejected) else $error("reject pulse longer than one cycle");
endmodule : fwp_checker

//--- verification/test_flash_write_protect_and_timing.sv
// Self-checking bench: host and device ends joined over the flash link
`timescale 1ns/1ps
module test_flash_write_protect_and_timing
	import fwp_pkg::*;
;
	localparam int PGC = 20;
	localparam int ERC = 400;
	localparam int RUN = 40;
	logic clk_sys = 1'b0;
	logic clk_dev = 1'b0;
	logic rstn = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [10:0] status_out;
	logic op_done;
	logic cmd_rejected;
	logic [31:0] rd;
	logic err;
	int error_cnt = 0;
	int samples_checked = 0;
	int n_done = 0;
	int n_rej = 0;
	int quiet = 0;
	int gap = 0;

	fwp_if u_link ();
	fwp_spi_host #(.RUN_CYC(RUN)) u_fwp_spi_host (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(u_link.host));
	fwp_flash_dev #(.PROG_CYC(PGC), .ERASE_CYC(ERC)) u_fwp_flash_dev (.clk_sys(clk_dev), .rstn(rstn),
		.link(u_link.device), .status_out(status_out), .op_done(op_done), .cmd_rejected(cmd_rejected));
	fwp_checker #(.ERASE_CYC(ERC)) u_fwp_checker (.clk_sys(clk_sys), .clk_dev(clk_dev), .rstn(rstn),
		.cs_n(u_link.cs_n), .sclk(u_link.sclk), .wp_n(u_link.wp_n), .miso_line(u_link.miso_line),
		.status_out(status_out), .op_done(op_done), .cmd_rejected(cmd_rejected));

	// ------------------------------------------------------------
	// Clocks, pulse counters and frame gap monitor
	// ------------------------------------------------------------
	initial forever #20 clk_sys = ~clk_sys;
	// Device clock is offset so the two domains never line up
	initial begin
		#7;
		forever #16 clk_dev = ~clk_dev;
	end
	always @(posedge clk_dev) begin
		if (op_done === 1'b1) n_done <= n_done + 1;
		if (cmd_rejected === 1'b1) n_rej <= n_rej + 1;
	end
	// Idle run before each frame start, to see how long a suspend was held back
	always @(posedge clk_sys) begin
		quiet <= (u_link.cs_n === 1'b1) ? quiet + 1 : 0;
		if (u_link.cs_n === 1'b0 && quiet != 0) gap <= quiet;
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Hands one command to the host and waits until its frames are out
	task automatic cmd(input logic [12:0] c, input logic [31:0] a);
		int t;
		apb(1'b1, REG_ARG, a);
		apb(1'b1, REG_CMD, {19'h00000, c});
		t = 0;
		do begin
			apb(1'b0, REG_STAT, 32'h00000000);
			t++;
		end while (rd[0] !== 1'b0 && t < 400);
		chk({31'h0, rd[0]}, 32'h0, "command frames sent");
		repeat (12) @(posedge clk_sys);
	endtask : cmd

	task automatic settle(input int d, input int r);
		int t;
		t = 0;
		while ((n_done < d || n_rej < r) && t < 1000) begin
			@(posedge clk_sys);
			t++;
		end
		chk(32'(n_done), 32'(d), "done count");
		chk(32'(n_rej), 32'(r), "reject count");
	endtask : settle

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin : main
		logic [7:0] ops [6];
		logic [31:0] rows [11];
		logic [10:0] rej_row;
		int d;
		int r;
		int t;
		ops = '{OP_ERS_PAGE, OP_ERS_SECT, OP_ERS_32K, OP_ERS_64K, OP_ERS_CHIP, OP_ERS_CHIP2};
		// Status byte in the top byte, sector address below
		rows = '{32'h043f0000, 32'h043e0000, 32'h24000000, 32'h243f0000, 32'h443ff000, 32'h443fe000,
			32'h64000000, 32'h64001000, 32'h1c200000, 32'h18200000, 32'h003ff000};
		rej_row = 11'b10101010110;
		d = 0;
		r = 0;
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		chk({21'h0, status_out}, {24'h0, STATUS_RESET}, "status after reset");
		apb(1'b0, REG_STAT, 32'h0);
		chk({31'h0, rd[2]}, 32'h0, "power-up wait flag");
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h1, "ctrl reset");
		apb(1'b0, 12'h010, 32'h0);
		chk({rd[30:0], err}, 32'h1, "unmapped access");
		t = 0;
		do begin
			apb(1'b0, REG_STAT, 32'h0);
			t++;
		end while (rd[2] !== 1'b1 && t < 1000);
		chk({31'h0, rd[2]}, 32'h1, "power-up wait done");
		$display("test reset finished");
		cmd({5'b00100, OP_PROG}, 32'h00001000);
		settle(d, ++r);
		cmd({5'b10000, OP_SET_WL}, 32'h0);
		settle(d, ++r);
		chk({21'h0, status_out}, 32'h0, "latch after short frame");
		cmd({5'b01001, OP_RD_STAT}, 32'h0);
		apb(1'b0, REG_STAT, 32'h0);
		chk({24'h0, rd[15:8]}, 32'h02, "status byte with latch");
		cmd({5'b01100, OP_PROG}, 32'h00010055);
		settle(++d, r);
		chk({21'h0, status_out}, 32'h0, "latch cleared after program");
		cmd({5'b01000, OP_CLR_WL}, 32'h0);
		chk({21'h0, status_out}, 32'h0, "latch cleared by clear command");
		foreach (ops[i]) begin
			cmd({2'b01, (ops[i] == OP_ERS_CHIP || ops[i] == OP_ERS_CHIP2) ? 3'd0 : 3'd3, ops[i]}, 32'h0);
			settle(++d, r);
		end
		cmd({5'b00100, OP_READ}, 32'h00100000);
		apb(1'b0, REG_STAT, 32'h0);
		chk({24'h0, rd[15:8]}, 32'hff, "erased array byte");
		$display("test program and erase finished");
		foreach (rows[i]) begin
			cmd({5'b01001, OP_WR_STAT}, {rows[i][31:24], 24'h0});
			chk({27'h0, status_out[6:2]}, {27'h0, rows[i][30:26]}, "protect bits");
			cmd({5'b01011, OP_ERS_SECT}, {rows[i][23:0], 8'h00});
			if (rej_row[10 - i]) settle(d, ++r);
			else settle(++d, r);
		end
		// Two-byte status write also sets both lock bits, so the pin guard covers them too
		cmd({5'b01010, OP_WR_STAT}, 32'h84010000);
		apb(1'b1, REG_CTRL, 32'h0);
		cmd({5'b01010, OP_WR_STAT}, 32'h0);
		chk({21'h0, status_out}, 32'h184, "protect and lock bits with pin low");
		apb(1'b1, REG_CTRL, 32'h1);
		cmd({5'b01010, OP_WR_STAT}, 32'h0);
		chk({21'h0, status_out}, 32'h0, "protect bits with pin high");
		$display("test protection finished");
		cmd({5'b01011, OP_ERS_SECT}, 32'h0);
		cmd({5'b00000, OP_SUSPEND}, 32'h0);
		chk({31'h0, status_out[9]}, 32'h1, "suspended");
		cmd({5'b00000, OP_RESUME}, 32'h0);
		apb(1'b0, REG_STAT, 32'h0);
		chk({31'h0, rd[1]}, 32'h1, "suspend hold running");
		cmd({5'b00000, OP_SUSPEND}, 32'h0);
		chk({31'h0, status_out[9]}, 32'h1, "suspended again");
		chk({31'h0, gap >= RUN}, 32'h1, "resume to suspend spacing");
		cmd({5'b00000, OP_RESUME}, 32'h0);
		settle(++d, r);
		$display("test suspend finished");
		cmd({5'b00000, OP_DEEP_PD}, 32'h0);
		cmd({5'b00000, OP_SET_WL}, 32'h0);
		settle(d, ++r);
		chk({21'h0, status_out}, 32'h400, "deep power-down status");
		cmd({5'b00000, OP_RELEASE_PD}, 32'h0);
		chk({21'h0, status_out}, 32'h0, "released");
		$display("test power-down finished");
		stop_test();
	end

	// Cuts a hang short well past the expected run length
	initial begin
		#2400000;
		error_cnt++;
		stop_test();
	end
endmodule : test_flash_write_protect_and_timing
